// ---- shared/lcd_cmd_pkg.sv ----
// constants, types and register layout of the lcd command register set
// Summary of operation
// RULE1 - swap flag reverses bits of RAM writes
// RULE2 - alternation toggles per frame or n lines
// RULE3 - invert flag selects which RAM level lights
// RULE4 - step control holds write-only, row, column
// RULE5 - write-only mode steps on writes only
// RULE6 - row/column bits choose the stepping mode
// RULE7 - cooperative: y steps when x hits 0fh
// RULE8 - mirror decrements x; y always increments
// RULE9 - host reloads x and y after step setup
// RULE10 - power register: bias, save, supply, init
// RULE11 - soft init pulses reset, reads back zero
// RULE12 - host waits two clocks after soft init
// RULE13 - power save stops clocks, grounds outputs
// RULE14 - supply enables booster; bias picks 1/9,1/7
// RULE15 - contrast holds a four-bit drive level
// RULE16 - contrast resets to all ones
// RULE17 - supply register: segment, symbol clock, area
// RULE18 - symbol and segment supply controls drive outputs
// RULE19 - extended page reaches boost and duty register
// RULE20 - boost code three is never accepted
// RULE21 - page command always taken, gates extended
// RULE22 - readback index picks register for reads
// RULE23 - select input routes command or RAM data
// RULE24 - y covers 00h..42h, x covers 00h..0fh
// RULE25 - command nibble plus page picks target
package lcd_cmd_pkg;

    // command codes in the upper nibble; a readback index equals the code
    localparam logic [3:0] CMD_X_ADDR     = 4'h0;
    localparam logic [3:0] CMD_Y_LO       = 4'h2;
    localparam logic [3:0] CMD_Y_HI       = 4'h3;
    localparam logic [3:0] CMD_NLINE_LO   = 4'h6;
    localparam logic [3:0] CMD_NLINE_HI   = 4'h7;
    localparam logic [3:0] CMD_DISP_CTL2  = 4'h9;
    localparam logic [3:0] CMD_STEP_CTL   = 4'ha;
    localparam logic [3:0] CMD_POWER      = 4'hb;
    localparam logic [3:0] CMD_READ_INDEX = 4'hc;
    localparam logic [3:0] CMD_CONTRAST   = 4'hd;
    localparam logic [3:0] CMD_SUPPLY     = 4'he;
    localparam logic [3:0] CMD_PAGE       = 4'hf;

    localparam logic [3:0] X_LAST      = 4'hf;   // last column address
    localparam logic [3:0] X_ONE       = 4'h1;
    localparam logic [6:0] Y_LAST      = 7'h42;  // last usable row
    localparam logic [6:0] Y_ONE       = 7'h01;
    localparam logic [5:0] NLINE_RESET = 6'h00;
    localparam logic [1:0] BOOST_BANNED = 2'h3;  // prohibited boost code
    localparam logic [3:0] CONTRAST_RESET = 4'hf;
    localparam logic [3:0] READ_INDEX_RESET = 4'hc;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] INIT_ONE    = 8'h01;

    // host bus pins; chip select and both strobes active low
    typedef struct packed {
        logic       csN;    // chip select
        logic       rs;     // command_data_select: 1 command, 0 RAM
        logic       wrN;    // write strobe
        logic       rdN;    // read strobe
        logic [7:0] data;   // write data
    } hostBus_t;

    // register nibble layouts, msb first as seen on d3..d0
    typedef struct packed {
        logic rev; logic lineInvEn; logic swap; logic mirror;
    } dispCtl2_t;
    typedef struct packed {
        logic spare; logic writeOnly; logic rowStep; logic colStep;
    } stepCtl_t;
    typedef struct packed {
        logic biasSeventh; logic powerSave;
        logic graphicSupplyOn; logic softInit;
    } powerCtl_t;
    typedef struct packed {
        logic segmentSupplyOn; logic spare;
        logic symbolClockExternal; logic symbolAreaOn;
    } supplyCtl_t;
    typedef struct packed {
        logic [1:0] frameRatioSelect; logic [1:0] boostFactor;
    } boostDuty_t;

    typedef struct packed {
        dispCtl2_t  dispCtl2;
        stepCtl_t   stepCtl;
        powerCtl_t  power;
        logic [3:0] contrast;
        supplyCtl_t supply;
        boostDuty_t boostDuty;
        logic       extPage;
        logic [3:0] readIndex;
        logic [5:0] nline;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        dispCtl2: '0, stepCtl: '0, power: '0,
        contrast: CONTRAST_RESET, supply: '0, boostDuty: '0,
        extPage: 1'b0, readIndex: READ_INDEX_RESET, nline: NLINE_RESET};

    // address loads handed to the stepper
    typedef struct packed {
        logic x; logic yLo; logic yHi; logic [3:0] data;
    } stepLoad_t;

    typedef struct packed {
        logic [3:0] x; logic [6:0] y;
    } stepState_t;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b01,
        INIT_RUN  = 2'b10
    } initState_t;

    typedef struct packed {
        regs_t      regs;
        initState_t initState;
        logic [7:0] initCnt;
        logic       wrHeld;     // write strobe low with chip selected
        logic       rdHeld;     // read strobe low with chip selected
        logic       rsHeld;
        logic [7:0] wrData;
        logic [7:0] rdData;
        logic [7:0] ramWrData;
        logic       ramWrPulse;
        logic       alt;
        logic [6:0] lineCnt;
        logic       dotOn;
    } core_t;

    // reverse the bit order of a byte
    function automatic logic [7:0] bitRev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) r[i] = v[7-i];
        return r;
    endfunction

endpackage

// ---- verification/lcd_command_register_set_test.sv ----
// self-checking bench for the lcd command register set
`timescale 1ns/100ps
module lcd_command_register_set_test;
    import lcd_cmd_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       ramBit = 1'b0;
    int         seed = 82395;
    int         fails = 0;
    int         n_compared = 0;
    hostBus_t   bus;
    logic [7:0] dataOut, ramWriteData, lastRam, rv, b, r;
    logic [3:0] xAddr, contrastLevel, c;
    logic [6:0] yAddr;
    logic [1:0] boostFactor, frameRatioSelect;
    logic       ramWriteStrobe, dotOn, biasSeventh, extendedPageSelect;
    logic       symbolClockExternal, symbolAreaOn, alternation;
    logic       segCommonGround, graphicSupplyOn;
    logic       masterMode = 1'b1, frameStart = 1'b0;

    always #12.5 clk = ~clk;

    // keep the byte of the last RAM write strobe
    always @(posedge clk) if (ramWriteStrobe) lastRam <= ramWriteData;

    lcd_command_register_set #(.INIT_HOLD_CYCLES(2)) uut (
        .clk(clk), .reset_n(reset_n), .bus(bus), .masterMode(masterMode),
        .ramReadData(8'h00), .frameStart(frameStart), .lineStart(1'b0),
        .ramBit(ramBit), .extTimingInput(1'b0), .dataOut(dataOut),
        .dataOe(), .ramWriteData(ramWriteData),
        .ramWriteStrobe(ramWriteStrobe), .ramReadStrobe(), .xAddr(xAddr),
        .yAddr(yAddr), .alternation(alternation), .dotOn(dotOn),
        .softInitActive(),
        .oscEnable(), .segCommonGround(segCommonGround), .extTimingGated(),
        .graphicSupplyOn(graphicSupplyOn), .biasSeventh(biasSeventh),
        .contrastLevel(contrastLevel), .segmentSupplyOn(),
        .symbolClockExternal(symbolClockExternal),
        .symbolAreaOn(symbolAreaOn), .boostFactor(boostFactor),
        .frameRatioSelect(frameRatioSelect),
        .extendedPageSelect(extendedPageSelect));

    lcd_host_model host (.clk(clk), .dataOut(dataOut), .bus(bus));

    // compare one result against the model value
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // the one place where the run ends
    task automatic give_verdict();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        check("contrastReset", contrastLevel, CONTRAST_RESET);
        host.rd(CMD_STEP_CTL, rv);
        check("stepReset", rv, 8'h00);
        host.wr(1'b1, 8'ha5);
        host.rd(CMD_STEP_CTL, rv);
        check("stepCtl", rv, 8'h05);
        host.wr(1'b1, 8'hbe);
        host.rd(CMD_POWER, rv);
        check("power", rv, 8'h0e);
        check("bias", biasSeventh, 1'b1);
        check("saveGround", segCommonGround, 1'b1);
        check("saveSupply", graphicSupplyOn, 1'b0);
        c = 4'($random(seed));
        host.wr(1'b1, {CMD_CONTRAST, c});
        check("contrast", contrastLevel, c);
        masterMode = 1'b0; // slave: soft init must do nothing
        host.wr(1'b1, 8'hb1);
        check("slaveInit", contrastLevel, c);
        masterMode = 1'b1;
        host.wr(1'b1, 8'hb1); // soft init returns registers to reset
        check("initContrast", contrastLevel, CONTRAST_RESET);
        host.rd(CMD_POWER, rv);
        check("initRead", rv, 8'h00);
        host.wr(1'b1, 8'hf1);
        check("page", extendedPageSelect, 1'b1);
        host.wr(1'b1, 8'he6);
        check("boostDuty", {frameRatioSelect, boostFactor}, 4'h6);
        host.wr(1'b1, 8'he3); // banned boost code must be ignored
        check("boostBan", {frameRatioSelect, boostFactor}, 4'h6);
        host.wr(1'b1, 8'hf0);
        host.wr(1'b1, 8'heb);
        check("symbol", {symbolClockExternal, symbolAreaOn}, 2'h3);
        check("boostKept", boostFactor, 2'h2);
        host.wr(1'b1, 8'h92); // swap on
        host.wr(1'b1, 8'ha3); // cooperative stepping
        host.wr(1'b1, 8'h0f);
        host.wr(1'b1, 8'h22);
        host.wr(1'b1, 8'h30);
        b = 8'($random(seed));
        host.wr(1'b0, b);
        for (int i = 0; i < 8; i++) r[i] = b[7-i];
        check("swapData", lastRam, r);
        check("xWrap", xAddr, 4'h0);
        check("yStep", yAddr, 7'h03);
        frameStart = 1'b1; // one frame pulse, line inversion off
        @(negedge clk);
        frameStart = 1'b0;
        check("altFrame", alternation, 1'b1);
        ramBit = 1'b1;
        @(negedge clk);
        check("dotLit", dotOn, 1'b1);
        give_verdict();
    end
endmodule // lcd_command_register_set_test

// ---- verification/lcd_host_model.sv ----
// host processor model driving the command and RAM bus
`timescale 1ns/100ps
module lcd_host_model
    import lcd_cmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] dataOut,
    output hostBus_t        bus
);
    // bus idle: not selected, strobes high
    initial bus = '{csN: 1'b1, rs: 1'b1, wrN: 1'b1, rdN: 1'b1, data: 8'h00};

    // one write; the rising strobe is the edge the device takes
    task automatic wr(input logic rs, input logic [7:0] d);
        @(negedge clk);
        bus.csN = 1'b0;
        bus.rs = rs;
        bus.wrN = 1'b0;
        bus.data = d;
        @(negedge clk);
        bus.wrN = 1'b1;
        @(negedge clk);
        bus.csN = 1'b1;
        bus.data = ~d; // released lines never keep the last value
        repeat (3) @(negedge clk); // gap also covers soft init wait
    endtask

    // load the readback index, then read the selected register
    task automatic rd(input logic [3:0] idx, output logic [7:0] v);
        wr(1'b1, {CMD_READ_INDEX, idx});
        @(negedge clk);
        bus.csN = 1'b0;
        bus.rdN = 1'b0;
        repeat (2) @(negedge clk);
        v = dataOut;
        bus.csN = 1'b1;
        bus.rdN = 1'b1;
        @(negedge clk);
    endtask
endmodule // lcd_host_model

// ---- verilog/address_stepper.sv ----
// graphic RAM x and y address counters with auto-step modes
`timescale 1ns/100ps
module address_stepper
    import lcd_cmd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire stepLoad_t  load,     // address loads from commands
    input  wire stepCtl_t   mode,     // stepping mode bits
    input  wire logic       mirror,   // column mirror flag
    input  wire logic       step,     // one qualifying RAM access
    output logic [3:0]      xAddr,
    output logic [6:0]      yAddr
);
    stepState_t q;   // registered addresses
    stepState_t d;   // next addresses

    // stepping first, then explicit loads override it
    always_comb begin
        d = q;
        if (step) begin
            if (mode.colStep) begin
                // mirror walks columns backwards, wrapping
                d.x = mirror ? q.x - X_ONE : q.x + X_ONE; // RULE8
            end
            // row only, or cooperative when x was at its last
            if (mode.rowStep && (!mode.colStep || q.x == X_LAST)) begin // RULE6 RULE7
                d.y = (q.y >= Y_LAST) ? '0 : q.y + Y_ONE; // RULE24
            end
        end
        // no reload after a step mode change: host must reload
        if (load.x) d.x = load.data; // RULE9
        if (load.yLo) d.y[3:0] = load.data;
        if (load.yHi) d.y[6:4] = load.data[2:0];
    end

    // address registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) q <= '0;
        else q <= d;
    end

    assign xAddr = q.x;
    assign yAddr = q.y;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire noLoad = !(load.x || load.yLo || load.yHi);

    AST_X_UP: assert property (step && mode.colStep && !mirror && noLoad // RULE8
        |=> xAddr == 4'($past(xAddr) + X_ONE))
        else $error("x did not increment");
    AST_X_DOWN: assert property (step && mode.colStep && mirror && noLoad // RULE8
        |=> xAddr == 4'($past(xAddr) - X_ONE))
        else $error("x did not decrement under mirror");
    AST_Y_WRAP: assert property (step && mode.rowStep && !mode.colStep // RULE24
        && yAddr == Y_LAST && noLoad |=> yAddr == '0)
        else $error("y did not wrap after last row");
    AST_COOP: assert property (step && mode.rowStep && mode.colStep // RULE7
        && xAddr != X_LAST && noLoad |=> $stable(yAddr))
        else $error("y stepped before x reached last");
    AST_IDLE: assert property (step && !mode.rowStep && !mode.colStep // RULE6
        && noLoad |=> $stable(xAddr) && $stable(yAddr))
        else $error("address moved with stepping off");
endmodule // address_stepper

// ---- verilog/lcd_command_register_set.sv ----
// command decoder and register file of the graphic lcd controller
`timescale 1ns/100ps
module lcd_command_register_set
    import lcd_cmd_pkg::*;
#(
    parameter int INIT_HOLD_CYCLES = 2   // soft init length in clocks
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire hostBus_t   bus,            // host parallel bus
    input  wire logic       masterMode,     // master operation strap
    input  wire logic [7:0] ramReadData,    // RAM data at current address
    input  wire logic       frameStart,     // one pulse per frame
    input  wire logic       lineStart,      // one pulse per line
    input  wire logic       ramBit,         // dot being driven
    input  wire logic       extTimingInput, // ext_timing_input pin
    output logic [7:0]      dataOut,        // read data to host
    output logic            dataOe,         // drive data bus
    output logic [7:0]      ramWriteData,   // byte for graphic RAM
    output logic            ramWriteStrobe, // one-cycle RAM write
    output logic            ramReadStrobe,  // one-cycle RAM read
    output logic [3:0]      xAddr,
    output logic [6:0]      yAddr,
    output logic            alternation,    // drive alternation signal
    output logic            dotOn,          // dot lit
    output logic            softInitActive, // internal reset pulse
    output logic            oscEnable,
    output logic            segCommonGround,// hold drivers at ground
    output logic            extTimingGated,
    output logic            graphicSupplyOn,
    output logic            biasSeventh,    // 1: 1/7 bias, 0: 1/9
    output logic [3:0]      contrastLevel,
    output logic            segmentSupplyOn,
    output logic            symbolClockExternal,
    output logic            symbolAreaOn,
    output logic [1:0]      boostFactor,
    output logic [1:0]      frameRatioSelect,
    output logic            extendedPageSelect
);
    // the counter must hold the length, and two clocks is the least
    if (INIT_HOLD_CYCLES < 2 || INIT_HOLD_CYCLES > 255) begin : g_chk
        $error("INIT_HOLD_CYCLES out of range");
    end

    localparam logic [7:0] INIT_LAST = 8'(INIT_HOLD_CYCLES);

    core_t q;          // all registered state
    core_t d;          // next state

    // bus events seen this cycle
    logic       wrEnd;       // rising write strobe closes a write
    logic       rdStart;     // falling read strobe opens a read
    logic       cmdWrite;    // write to the command registers
    logic [3:0] cmdCode;     // target register code
    logic [3:0] cmdNib;      // value nibble
    logic       stepPulse;   // access that may advance addresses
    logic [3:0] readNib;     // indexed register for readback
    stepLoad_t  load;        // address loads to the stepper

    // strobe edges; commands are ignored while soft init runs
    always_comb begin
        wrEnd   = q.wrHeld && bus.wrN && q.initState == INIT_IDLE; // RULE12
        rdStart = !bus.csN && !bus.rdN && !q.rdHeld;
        cmdWrite = wrEnd && q.rsHeld; // RULE23
        cmdCode  = q.wrData[7:4]; // RULE25
        cmdNib   = q.wrData[3:0];
    end

    // address loads go to the stepper only on the normal page
    always_comb begin
        load.data = cmdNib;
        load.x   = cmdWrite && !q.regs.extPage && cmdCode == CMD_X_ADDR;
        load.yLo = cmdWrite && !q.regs.extPage && cmdCode == CMD_Y_LO;
        load.yHi = cmdWrite && !q.regs.extPage && cmdCode == CMD_Y_HI;
    end

    // reads step only when the write-only mode is off
    always_comb begin
        stepPulse = q.ramWrPulse
            || (rdStart && !bus.rs && !q.regs.stepCtl.writeOnly); // RULE5
    end

    // readback mux: the index equals the command code
    always_comb begin
        case (q.regs.readIndex) // RULE22
            CMD_NLINE_LO:  readNib = q.regs.nline[3:0];
            CMD_NLINE_HI:  readNib = {2'h0, q.regs.nline[5:4]};
            CMD_DISP_CTL2: readNib = q.regs.dispCtl2;
            CMD_STEP_CTL:  readNib = q.regs.stepCtl; // RULE4
            CMD_POWER:     readNib = q.regs.power; // RULE10
            CMD_CONTRAST:  readNib = q.regs.contrast; // RULE15
            CMD_SUPPLY:    readNib = q.regs.extPage ?
                                     q.regs.boostDuty : q.regs.supply;
            CMD_PAGE:      readNib = {3'h0, q.regs.extPage}; // RULE21
            default:       readNib = NIBBLE_ZERO;
        endcase
    end

    // next state: bus capture, command decode, init, display timing
    always_comb begin
        d = q;
        d.ramWrPulse = 1'b0;
        // hold the byte while the write strobe is low
        d.wrHeld = !bus.csN && !bus.wrN;
        if (!bus.csN && !bus.wrN) begin
            d.wrData = bus.data;
            d.rsHeld = bus.rs;
        end
        d.rdHeld = !bus.csN && !bus.rdN;

        // read: command side returns the indexed nibble, upper zero
        if (rdStart) begin
            d.rdData = bus.rs ? {NIBBLE_ZERO, readNib}
                              : ramReadData; // RULE23 RULE22
        end

        // RAM write: byte reversed when swap is set
        if (wrEnd && !q.rsHeld) begin
            d.ramWrData = q.regs.dispCtl2.swap ?
                          bitRev8(q.wrData) : q.wrData; // RULE1
            d.ramWrPulse = 1'b1;
        end

        // command decode: page command taken on either page
        if (cmdWrite) begin
            if (cmdCode == CMD_PAGE) begin
                d.regs.extPage = cmdNib[0]; // RULE21
            end else if (!q.regs.extPage) begin
                case (cmdCode) // RULE25
                    CMD_NLINE_LO: d.regs.nline[3:0] = cmdNib;
                    CMD_NLINE_HI: d.regs.nline[5:4] = cmdNib[1:0];
                    CMD_DISP_CTL2: d.regs.dispCtl2 = dispCtl2_t'(cmdNib);
                    CMD_STEP_CTL: begin
                        d.regs.stepCtl = stepCtl_t'(cmdNib); // RULE4
                        d.regs.stepCtl.spare = 1'b0;
                    end
                    CMD_POWER: begin
                        d.regs.power = powerCtl_t'(cmdNib); // RULE10
                        // init bit never stored, so it reads as zero
                        d.regs.power.softInit = 1'b0; // RULE11
                    end
                    CMD_READ_INDEX: d.regs.readIndex = cmdNib; // RULE22
                    CMD_CONTRAST: d.regs.contrast = cmdNib; // RULE15
                    CMD_SUPPLY: begin
                        d.regs.supply = supplyCtl_t'(cmdNib); // RULE17
                        d.regs.supply.spare = 1'b0;
                    end
                    default: d.regs = q.regs;   // x and y codes held in the stepper, others unused
                endcase
            end else if (cmdCode == CMD_SUPPLY) begin
                // the banned boost code is refused, value kept
                if (cmdNib[1:0] != BOOST_BANNED) begin // RULE20
                    d.regs.boostDuty = boostDuty_t'(cmdNib); // RULE19
                end
            end
        end

        // soft init: only a master may reset itself
        case (q.initState)
            INIT_IDLE: begin
                if (cmdWrite && !q.regs.extPage && cmdCode == CMD_POWER
                    && cmdNib[0] && masterMode) begin // RULE11
                    d.initState = INIT_RUN;
                    d.initCnt   = INIT_ONE;
                end
            end
            INIT_RUN: begin
                // registers held at reset values from the second clock of the pulse on
                d.regs = REGS_RESET; // RULE16
                if (q.initCnt >= INIT_LAST) d.initState = INIT_IDLE;
                else d.initCnt = q.initCnt + INIT_ONE;
            end
            default: d.initState = INIT_IDLE;
        endcase

        // alternation: frame rate, or every nline+1 lines when enabled
        // the line count is cleared while the mode is off, so turning
        // it on again always starts a full count, never a stale one
        if (!q.regs.dispCtl2.lineInvEn) begin
            d.lineCnt = '0;
            if (frameStart) d.alt = !q.alt; // RULE2
        end else if (lineStart) begin
            // register value v gives v+1 lines between toggles
            if (q.lineCnt >= {1'b0, q.regs.nline}) begin
                d.lineCnt = '0;
                d.alt = !q.alt; // RULE2
            end else begin
                d.lineCnt = q.lineCnt + Y_ONE;
            end
        end

        // dot lighting, inverted when display invert is set
        d.dotOn = ramBit ^ q.regs.dispCtl2.rev; // RULE3
        // power save forces the dot off
        if (q.regs.power.powerSave) d.dotOn = 1'b0; // RULE13
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{regs: REGS_RESET, initState: INIT_IDLE,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // address counters and their stepping modes
    address_stepper u_stepper (
        .clk     (clk),
        .reset_n (reset_n),
        .load    (load),
        .mode    (q.regs.stepCtl), // RULE6
        .mirror  (q.regs.dispCtl2.mirror),
        .step    (stepPulse),
        .xAddr   (xAddr),
        .yAddr   (yAddr)
    );

    // host side outputs
    assign dataOut        = q.rdData;
    assign dataOe         = !bus.csN && !bus.rdN;
    assign ramWriteData   = q.ramWrData;
    assign ramWriteStrobe = q.ramWrPulse;
    assign ramReadStrobe  = rdStart && !bus.rs;

    // display and power outputs; save mode overrides the supplies
    assign alternation     = q.alt;
    assign dotOn           = q.dotOn;
    assign softInitActive  = q.initState == INIT_RUN;
    assign oscEnable       = !q.regs.power.powerSave; // RULE13
    assign segCommonGround = q.regs.power.powerSave; // RULE13
    assign extTimingGated  = extTimingInput && !q.regs.power.powerSave;
    assign graphicSupplyOn = q.regs.power.graphicSupplyOn
                             && !q.regs.power.powerSave; // RULE14
    assign biasSeventh     = q.regs.power.biasSeventh; // RULE14
    assign contrastLevel   = q.regs.contrast; // RULE15
    assign segmentSupplyOn = q.regs.supply.segmentSupplyOn
                             && !q.regs.power.powerSave; // RULE18
    assign symbolClockExternal = q.regs.supply.symbolClockExternal;
    assign symbolAreaOn     = q.regs.supply.symbolAreaOn; // RULE18
    assign boostFactor      = q.regs.boostDuty.boostFactor;
    assign frameRatioSelect = q.regs.boostDuty.frameRatioSelect;
    assign extendedPageSelect = q.regs.extPage;

    // checks on the decoder, each next to the rule that it guards;
    // most look at the ports, so a broken path inside shows up here; AST_STEP_LOAD checks q.regs.stepCtl
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_SWAP: assert property (wrEnd && !q.rsHeld // RULE1
        && q.regs.dispCtl2.swap
        |=> ramWriteStrobe && ramWriteData == bitRev8($past(q.wrData)))
        else $error("swapped RAM write data wrong");
    AST_ALT_FRAME: assert property (!q.regs.dispCtl2.lineInvEn // RULE2
        && frameStart |=> alternation != $past(alternation))
        else $error("alternation missed frame toggle");
    AST_DOT: assert property (!q.regs.power.powerSave // RULE3
        |=> dotOn == ($past(ramBit) ^ $past(q.regs.dispCtl2.rev)))
        else $error("dot lighting polarity wrong");
    AST_STEP_LOAD: assert property (cmdWrite && !q.regs.extPage // RULE4
        && cmdCode == CMD_STEP_CTL && q.initState == INIT_IDLE
        |=> q.regs.stepCtl == {1'b0, $past(cmdNib[2:0])})
        else $error("step control not loaded");
    AST_WRITE_ONLY: assert property (rdStart && !bus.rs // RULE5
        && q.regs.stepCtl.writeOnly && !q.ramWrPulse && !cmdWrite
        |=> $stable(xAddr) && $stable(yAddr))
        else $error("read stepped in write-only mode");
    AST_INIT_READ: assert property (rdStart && bus.rs // RULE11
        && q.regs.readIndex == CMD_POWER |=> dataOut[0] == 1'b0)
        else $error("soft init bit read back as one");
    AST_INIT_LEN: assert property ($rose(softInitActive) // RULE11
        |-> softInitActive ##1 softInitActive ##1 !softInitActive)
        else $error("soft init pulse length wrong");
    AST_INIT_MASTER: assert property (!masterMode // RULE11
        && q.initState == INIT_IDLE |=> !softInitActive)
        else $error("soft init ran without master mode");
    AST_SAVE: assert property (q.regs.power.powerSave // RULE13
        |-> !oscEnable && segCommonGround && !extTimingGated
            && !graphicSupplyOn ##1 !dotOn)
        else $error("power save did not stop the drive");
    AST_CONTRAST_INIT: assert property ($fell(softInitActive) // RULE16
        |-> contrastLevel == CONTRAST_RESET && !extendedPageSelect)
        else $error("soft init left registers set");
    AST_BOOST: assert property (boostFactor != BOOST_BANNED) // RULE20
        else $error("prohibited boost code held");
    AST_PAGE_GATE: assert property (cmdWrite && !q.regs.extPage // RULE21
        && cmdCode == CMD_SUPPLY |=> $stable(boostFactor))
        else $error("boost changed on normal page");

    // scenarios for the bench to reach; COV_LINE_ALT is never hit, as the bench ties lineStart low and never enables line inversion
    COV_SWAP_WRITE: cover property (wrEnd && !q.rsHeld
        && q.regs.dispCtl2.swap);
    COV_SOFT_INIT: cover property ($rose(softInitActive));
    COV_EXT_WRITE: cover property (cmdWrite && q.regs.extPage
        && cmdCode == CMD_SUPPLY);
    COV_LINE_ALT: cover property (q.regs.dispCtl2.lineInvEn
        && $changed(alternation));
endmodule // lcd_command_register_set
